// file: verilog/uafb_top.sv
// async frame formatter/checker with fractional baud generator
// assumes rxd synchronous to clock and a single-cycle strobe register port
// Operation
// - async framing only while link select zero
// - one low start bit, full bit
// - width code picks seven, eight, nine bits
// - stop bits drive line high
// - stop code picks half to two bits
// - bit order flag picks lsb/msb first
// - inversion flags flip whole frame per side
// - parity inserted on send, checked on receive
// - mode 10 even, mode 11 odd
// - mode 00 omits parity; 01 reserved
// - bit rate clock over ratio times (scaler plus one)
// - ratio code picks 16,8,6,4 or 1
// - scaler 20 bits, 5 fractional
// - fraction lengthens that many of 32 periods
// - slow clock mode restricts stop lengths
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module uafb_top (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 nrst,
    // register port
    input  wire uafb_pkg::uafb_busreq_type busReq,
    output var  logic [31:0]          rdData,
    // serial link
    input  wire logic                 rxd,
    output var  logic                 txd,
    // interrupt
    output var  logic                 irq
);
    import uafb_pkg::*;

    typedef struct packed {
        uafb_general_type  gen;
        uafb_frame_type    frm;
        logic [19:0]       scaler;
        logic [FLG_W-1:0]  flags;
        logic [FLG_W-1:0]  mask;
        logic [1:0][15:0]  cnt;
        logic [1:0][4:0]   acc;
        uafb_tx_type       txSt;
        logic [3:0]        txSub;
        logic [3:0]        txIdx;
        logic [5:0]        txStopLeft;
        logic [8:0]        txData;
        uafb_rx_type       rxSt;
        logic [3:0]        rxSub;
        logic [3:0]        rxIdx;
        logic [8:0]        rxShift;
        logic              rxPar;
        logic [8:0]        rxData;
        logic              rxParErr;
        logic              rxFrmErr;
        logic              txd;
        logic              irq;
        logic [31:0]       rdData;
    } uafb_state_type;

    localparam uafb_state_type RESET_STATE = '{
        gen: '{sampleRatio: RST_RATIO, default: 1'b0},
        frm: '{parity: RST_PARITY, stopLengthCode: RST_STOP, frameWidthCode: RST_WIDTH},
        scaler: RST_SCALER,
        txSt: TX_IDLE,
        rxSt: RX_IDLE,
        txd: 1'b1,
        default: '0
    };

    logic [1:0]        rstPipe;
    logic              rstSync;
    uafb_state_type    s;
    uafb_state_type    s_nxt;
    logic [4:0]        ratio;
    logic [3:0]        width;
    logic [8:0]        widthMask;
    logic [2:0]        stopHalves;
    logic [6:0]        stopProd;
    logic [5:0]        stopTicks;
    logic              asyncMode;
    logic [1:0][5:0]   accSum;
    logic [1:0][15:0]  limit;
    logic [1:0]        tick;
    logic              txBitEnd;
    logic [3:0]        txPos;
    logic              txLevel;
    logic              txParBit;
    logic              rxLevel;
    logic [3:0]        sampleAt;
    logic              rxSample;
    logic [3:0]        rxPos;
    logic              wrTx;
    logic [FLG_W-1:0]  events;
    logic [FLG_W-1:0]  flagClr;

    function automatic logic [4:0] ratioOf(input logic [2:0] code);
        case (code)
            RATIO_16:  ratioOf = 5'h10;
            RATIO_8:   ratioOf = 5'h08;
            RATIO_6:   ratioOf = 5'h06;
            RATIO_4:   ratioOf = 5'h04;
            RATIO_OFF: ratioOf = 5'h01;
            default:   ratioOf = 5'h10;
        endcase
    endfunction : ratioOf

    // reset release through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync = rstPipe[1];

    always_comb begin
        s_nxt = s;
        events = '0;
        asyncMode = (s.gen.linkSync == 1'b0);
        ratio = ratioOf(s.gen.sampleRatio);
        case (s.frm.frameWidthCode)
            WIDTH_7: width = 4'h7;
            WIDTH_9: width = 4'h9;
            default: width = 4'h8;
        endcase
        widthMask = 9'h1FF >> (4'h9 - width);
        // stop length in half bits; slow clock has only one or two
        case (s.frm.stopLengthCode)
            STOP_HALF:    stopHalves = (ratio == 5'h01) ? 3'h2 : 3'h1;
            STOP_ONEHALF: stopHalves = (ratio == 5'h01) ? 3'h4 : 3'h3;
            STOP_TWO:     stopHalves = 3'h4;
            default:      stopHalves = 3'h2;
        endcase
        stopProd = 7'(stopHalves * ratio);
        stopTicks = (stopProd[6:1] == 6'h00) ? 6'h01 : stopProd[6:1];

        // per-side baud tick: 1 + int cycles, plus one when fraction carries
        for (int c = 0; c < 2; c++) begin
            accSum[c] = {1'b0, s.acc[c]} + {1'b0, s.scaler[SCALER_FRAC_W-1:0]};
            limit[c] = {1'b0, s.scaler[SCALER_W-1:SCALER_FRAC_W]} + {15'h0, accSum[c][5]};
            tick[c] = (s.cnt[c] == limit[c]);
            if (tick[c]) begin
                s_nxt.cnt[c] = 16'h0000;
                s_nxt.acc[c] = accSum[c][4:0];
            end else begin
                s_nxt.cnt[c] = s.cnt[c] + 16'h0001;
            end
        end

        // transmitter
        wrTx = busReq.wrStb && (busReq.addr == OFS_TXDATA);
        txBitEnd = tick[0] && (s.txSub == 4'(ratio - 5'h01));
        if (tick[0]) begin
            s_nxt.txSub = txBitEnd ? 4'h0 : s.txSub + 4'h1;
        end
        txPos = s.gen.highBitLeading ? (width - 4'h1 - s.txIdx) : s.txIdx;
        txParBit = ^(s.txData & widthMask) ^ s.frm.parity[0];
        case (s.txSt)
            TX_IDLE: begin
                if (wrTx && s.gen.txEnable && asyncMode) begin
                    s_nxt.txData = busReq.wrData[8:0];
                    s_nxt.txSt = TX_START;
                    s_nxt.cnt[0] = 16'h0000;
                    s_nxt.acc[0] = 5'h00;
                    s_nxt.txSub = 4'h0;
                end
            end
            TX_START: begin
                if (txBitEnd) begin
                    s_nxt.txSt = TX_DATA;
                    s_nxt.txIdx = 4'h0;
                end
            end
            TX_DATA: begin
                if (txBitEnd) begin
                    if (s.txIdx == width - 4'h1) begin
                        if (s.frm.parity[1]) begin
                            s_nxt.txSt = TX_PAR;
                        end else begin
                            s_nxt.txSt = TX_STOP;
                            s_nxt.txStopLeft = stopTicks;
                        end
                    end else begin
                        s_nxt.txIdx = s.txIdx + 4'h1;
                    end
                end
            end
            TX_PAR: begin
                if (txBitEnd) begin
                    s_nxt.txSt = TX_STOP;
                    s_nxt.txStopLeft = stopTicks;
                end
            end
            TX_STOP: begin
                if (tick[0]) begin
                    if (s.txStopLeft == 6'h01) begin
                        s_nxt.txSt = TX_IDLE;
                        events[FLG_TXDONE] = 1'b1;
                    end else begin
                        s_nxt.txStopLeft = s.txStopLeft - 6'h01;
                    end
                end
            end
            default: s_nxt.txSt = TX_IDLE;
        endcase
        if (!(s.gen.txEnable && asyncMode)) begin
            s_nxt.txSt = TX_IDLE;
        end
        case (s.txSt)
            TX_START: txLevel = 1'b0;
            TX_DATA:  txLevel = s.txData[txPos];
            TX_PAR:   txLevel = txParBit;
            default:  txLevel = 1'b1;
        endcase
        s_nxt.txd = txLevel ^ s.gen.txPolarityFlip;

        // receiver, sampling mid-bit
        rxLevel = rxd ^ s.gen.rxPolarityFlip;
        sampleAt = (ratio == 5'h01) ? 4'h0 : 4'((ratio >> 1) - 5'h01);
        rxSample = tick[1] && (s.rxSub == sampleAt);
        if (tick[1]) begin
            s_nxt.rxSub = (s.rxSub == 4'(ratio - 5'h01)) ? 4'h0 : s.rxSub + 4'h1;
        end
        rxPos = s.gen.highBitLeading ? (width - 4'h1 - s.rxIdx) : s.rxIdx;
        case (s.rxSt)
            RX_IDLE: begin
                if (s.gen.rxEnable && asyncMode && !rxLevel) begin
                    s_nxt.rxSt = RX_START;
                    // without oversampling, first tick lands mid-bit
                    s_nxt.cnt[1] = (ratio == 5'h01) ? {2'b00, s.scaler[19:6]} : 16'h0000;
                    s_nxt.acc[1] = 5'h00;
                    s_nxt.rxSub = 4'h0;
                end
            end
            RX_START: begin
                if (rxSample) begin
                    s_nxt.rxSt = rxLevel ? RX_IDLE : RX_DATA;
                    s_nxt.rxIdx = 4'h0;
                    s_nxt.rxShift = 9'h000;
                end
            end
            RX_DATA: begin
                if (rxSample) begin
                    s_nxt.rxShift[rxPos] = rxLevel;
                    if (s.rxIdx == width - 4'h1) begin
                        s_nxt.rxSt = s.frm.parity[1] ? RX_PAR : RX_STOP;
                    end else begin
                        s_nxt.rxIdx = s.rxIdx + 4'h1;
                    end
                end
            end
            RX_PAR: begin
                if (rxSample) begin
                    s_nxt.rxPar = rxLevel;
                    s_nxt.rxSt = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rxSample) begin
                    s_nxt.rxSt = RX_IDLE;
                    s_nxt.rxData = s.rxShift;
                    s_nxt.rxParErr = s.frm.parity[1] &&
                        (s.rxPar != (^(s.rxShift & widthMask) ^ s.frm.parity[0]));
                    s_nxt.rxFrmErr = !rxLevel;
                    events[FLG_RXDONE] = 1'b1;
                    events[FLG_PARERR] = s_nxt.rxParErr;
                    events[FLG_FRMERR] = !rxLevel;
                end
            end
            default: s_nxt.rxSt = RX_IDLE;
        endcase
        if (!(s.gen.rxEnable && asyncMode)) begin
            s_nxt.rxSt = RX_IDLE;
        end

        // register writes
        if (busReq.wrStb) begin
            case (busReq.addr)
                OFS_GENERAL: s_nxt.gen = uafb_general_type'(busReq.wrData[8:0]);
                OFS_FRAME:   s_nxt.frm = uafb_frame_type'(busReq.wrData[7:0]);
                OFS_SCALER:  s_nxt.scaler = busReq.wrData[19:0];
                OFS_MASK:    s_nxt.mask = busReq.wrData[FLG_W-1:0];
                default:     s_nxt.mask = s.mask;
            endcase
        end

        // reads; flags clear on read, a new event wins
        flagClr = (busReq.rdStb && busReq.addr == OFS_FLAGS) ? s.flags : '0;
        s_nxt.flags = (s.flags & ~flagClr) | events;
        s_nxt.rdData = 32'h00000000;
        if (busReq.rdStb) begin
            case (busReq.addr)
                OFS_GENERAL: s_nxt.rdData = {23'h0, s.gen};
                OFS_FRAME:   s_nxt.rdData = {24'h0, s.frm};
                OFS_SCALER:  s_nxt.rdData = {12'h0, s.scaler};
                OFS_RXDATA:  s_nxt.rdData = {21'h0, s.rxFrmErr, s.rxParErr, s.rxData};
                OFS_FLAGS:   s_nxt.rdData = {28'h0, s.flags};
                OFS_MASK:    s_nxt.rdData = {28'h0, s.mask};
                OFS_STATE:   s_nxt.rdData = {30'h0, s.rxSt != RX_IDLE, s.txSt != TX_IDLE};
                default:     s_nxt.rdData = 32'h00000000;
            endcase
        end
        s_nxt.irq = |(s_nxt.flags & s_nxt.mask);
    end

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            s <= RESET_STATE;
        end else begin
            s <= s_nxt;
        end
    end

    assign txd = s.txd;
    assign irq = s.irq;
    assign rdData = s.rdData;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync);

    sequence s_frameBegin;
        (s.txSt == TX_IDLE) ##1 (s.txSt == TX_START);
    endsequence

    sequence s_lastDataBit;
        (s.txSt == TX_DATA) && txBitEnd && (s.txIdx == width - 4'h1);
    endsequence

    property p_idleHigh;
        (s.txSt == TX_IDLE) && !s.gen.txPolarityFlip |=> txd;
    endproperty
    a_idleHigh: assert property (p_idleHigh) else $error("tx not high at idle");

    property p_startLevel;
        s_frameBegin |=> (txd == s.gen.txPolarityFlip) [*2];
    endproperty
    a_startLevel: assert property (p_startLevel) else $error("start bit level wrong");

    property p_stopLevel;
        (s.txSt == TX_STOP) |=> (txd == !$past(s.gen.txPolarityFlip));
    endproperty
    a_stopLevel: assert property (p_stopLevel) else $error("stop bit level wrong");

    property p_parityBit;
        (s.txSt == TX_PAR) |=> (txd == ($past(txParBit) ^ $past(s.gen.txPolarityFlip)));
    endproperty
    a_parityBit: assert property (p_parityBit) else $error("parity bit wrong");

    property p_afterData;
        s_lastDataBit |=> (s.txSt == (s.frm.parity[1] ? TX_PAR : TX_STOP));
    endproperty
    a_afterData: assert property (p_afterData) else $error("data length wrong");

    property p_syncIdle;
        s.gen.linkSync |=> (s.txSt == TX_IDLE) && (s.rxSt == RX_IDLE);
    endproperty
    a_syncIdle: assert property (p_syncIdle) else $error("framing in sync mode");

    property p_tickPeriod;
        tick[0] && !(wrTx && (s.txSt == TX_IDLE)) |=> (s.cnt[0] == 16'h0000) &&
            (s.acc[0] == 5'($past(s.acc[0]) + $past(s.scaler[4:0])));
    endproperty
    a_tickPeriod: assert property (p_tickPeriod) else $error("baud tick period wrong");

    property p_parErrFlag;
        (s.rxSt == RX_STOP) && rxSample && s.frm.parity[1] &&
            (s.rxPar != (^(s.rxShift & widthMask) ^ s.frm.parity[0]))
            |=> s.rxParErr && s.flags[FLG_PARERR];
    endproperty
    a_parErrFlag: assert property (p_parErrFlag) else $error("parity error missed");

    property p_stopLength;
        (s.txSt == TX_STOP) && tick[0] && (s.txStopLeft == 6'h01) |=> (s.txSt == TX_IDLE);
    endproperty
    a_stopLength: assert property (p_stopLength) else $error("stop length wrong");

endmodule : uafb_top
`default_nettype wire

// file: verilog/uafb_pkg.sv
// constants, codes and carrier types of the async frame and baud block
// assumes a single clock domain and a word-wide plain register port
package uafb_pkg;

    // register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] OFS_GENERAL = 8'h00;
    localparam logic [7:0] OFS_FRAME   = 8'h04;
    localparam logic [7:0] OFS_SCALER  = 8'h08;
    localparam logic [7:0] OFS_TXDATA  = 8'h0C;
    localparam logic [7:0] OFS_RXDATA  = 8'h10;
    localparam logic [7:0] OFS_FLAGS   = 8'h14;
    localparam logic [7:0] OFS_MASK    = 8'h18;
    localparam logic [7:0] OFS_STATE   = 8'h1C;

    // sticky event bit positions in flags and mask
    localparam int FLG_TXDONE = 0;
    localparam int FLG_RXDONE = 1;
    localparam int FLG_PARERR = 2;
    localparam int FLG_FRMERR = 3;
    localparam int FLG_W      = 4;

    // frame width codes
    localparam logic [3:0] WIDTH_7 = 4'h1;
    localparam logic [3:0] WIDTH_8 = 4'h2;
    localparam logic [3:0] WIDTH_9 = 4'h3;

    // stop length codes
    localparam logic [1:0] STOP_HALF    = 2'h0;
    localparam logic [1:0] STOP_ONE     = 2'h1;
    localparam logic [1:0] STOP_ONEHALF = 2'h2;
    localparam logic [1:0] STOP_TWO     = 2'h3;

    // parity codes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD  = 2'h3;

    // oversampling codes and ratios
    localparam logic [2:0] RATIO_16  = 3'h0;
    localparam logic [2:0] RATIO_8   = 3'h1;
    localparam logic [2:0] RATIO_6   = 3'h2;
    localparam logic [2:0] RATIO_4   = 3'h3;
    localparam logic [2:0] RATIO_OFF = 3'h4;

    // baud scaler layout
    localparam int SCALER_W      = 20;
    localparam int SCALER_INT_W  = 15;
    localparam int SCALER_FRAC_W = 5;

    // values after reset
    localparam logic [3:0]  RST_WIDTH  = WIDTH_8;
    localparam logic [1:0]  RST_STOP   = STOP_ONE;
    localparam logic [1:0]  RST_PARITY = PAR_NONE;
    localparam logic [2:0]  RST_RATIO  = RATIO_16;
    localparam logic [19:0] RST_SCALER = 20'h00000;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PAR = 5'b01000,
        TX_STOP = 5'b10000
    } uafb_tx_type;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } uafb_rx_type;

    // general_setup_reg, bits 8..0
    typedef struct packed {
        logic       rxEnable;
        logic       txEnable;
        logic [2:0] sampleRatio;
        logic       rxPolarityFlip;
        logic       txPolarityFlip;
        logic       highBitLeading;
        logic       linkSync;
    } uafb_general_type;

    // frame_setup_reg, bits 7..0
    typedef struct packed {
        logic [1:0] parity;
        logic [1:0] stopLengthCode;
        logic [3:0] frameWidthCode;
    } uafb_frame_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wrData;
        logic        wrStb;
        logic        rdStb;
    } uafb_busreq_type;

endpackage : uafb_pkg

// file: verif/uafb_remote.sv
// far-side serial party: drives frames on rxd, samples frames from txd
// assumes both lines registered to clock and an idle-high pulled-up rxd
`timescale 1ns/1ns
`default_nettype none
module uafb_remote (
    // clock
    input  wire logic clock,
    // serial lines
    input  wire logic txd,
    output var  logic rxd
);
    initial rxd = 1'b1;

    // whole frame, line order, start bit in bit 0; back to pulled-up idle
    task automatic send(input logic [15:0] b, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            rxd <= b[i];
            repeat (per - 1) @(posedge clock);
        end
        @(posedge clock);
        rxd <= 1'b1;
    endtask : send

    // mid-bit samples of one frame, start bit in bit 0
    task automatic grab(input logic idle, input int n, input int per, output logic [15:0] b,
                        output logic late);
        int k;
        b = '0;
        k = 0;
        while (txd === idle && k < 3000) begin
            @(posedge clock);
            #1;
            k++;
        end
        late = (k >= 3000);
        repeat (per / 2) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            #1 b[i] = txd;
            if (i < n - 1) repeat (per) @(posedge clock);
        end
    endtask : grab
endmodule : uafb_remote
`default_nettype wire

// file: verif/uafb_tb.sv
// self-checking bench for uafb_top over its register port and serial lines
// assumes uafb_remote as the far party on txd/rxd
`timescale 1ns/1ns
`default_nettype none
module uafb_tb;
    import uafb_pkg::*;
    logic            clock   = 1'b0;
    logic            nrst    = 1'b0;
    uafb_busreq_type busReq  = '0;
    logic [31:0]     rdData;
    logic            rxd;
    logic            txd;
    logic            irq;
    int              badCount = 0;
    int              checked  = 0;
    logic [31:0]     v;
    logic [15:0]     got;
    logic [15:0]     exp;
    logic            late;
    int              n;
    int              lo;
    int              t;
    int              dd [4];
    logic [8:0]      cg [4] = '{9'h0B0, 9'h0B2, 9'h0B4, 9'h0B0};
    logic [7:0]      cf [4] = '{8'h12, 8'h91, 8'hF3, 8'h92};
    logic [8:0]      cd [4] = '{9'h0C5, 9'h05B, 9'h1A6, 9'h0FF};
    int              ratio [5] = '{16, 8, 6, 4, 1};

    always #50 clock = ~clock;

    uafb_top dut_u (
        .clock (clock),
        .nrst  (nrst),
        .busReq(busReq),
        .rdData(rdData),
        .rxd   (rxd),
        .txd   (txd),
        .irq   (irq)
    );

    uafb_remote far_u (
        .clock(clock),
        .txd  (txd),
        .rxd  (rxd)
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            badCount++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic closeOut;
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : closeOut

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        busReq.addr   <= a;
        busReq.wrData <= d;
        busReq.wrStb  <= 1'b1;
        @(posedge clock);
        busReq.wrStb  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        busReq.addr  <= a;
        busReq.rdStb <= 1'b1;
        @(posedge clock);
        busReq.rdStb <= 1'b0;
        #1 d = rdData;
    endtask : rd

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk("register", e, d);
    endtask : rdChk

    // cycles txd stays low after its fall, and cycles from that fall to irq
    task automatic span(output int low, output int tot);
        int k;
        k = 0;
        while (txd !== 1'b0 && k < 3000) begin
            @(posedge clock);
            #1 k++;
        end
        low = 0;
        tot = 0;
        while (txd === 1'b0 && tot < 3000) begin
            @(posedge clock);
            #1 low++;
            tot++;
        end
        while (irq !== 1'b1 && tot < 3000) begin
            @(posedge clock);
            #1 tot++;
        end
        if (k >= 3000 || tot >= 3000) begin
            badCount++;
            $display("unexpected wait: expected frame end seen timeout");
            closeOut;
        end
    endtask : span

    // line bits of a frame, start bit in bit 0; cnt gets the bit count
    function automatic logic [15:0] frameBits(input logic [8:0] gen, input logic [7:0] frm,
                                              input logic [8:0] d, output int cnt);
        int         w;
        logic [15:0] b;
        w = (frm[3:0] == WIDTH_7) ? 7 : (frm[3:0] == WIDTH_9) ? 9 : 8;
        b = '0;
        cnt = 1;
        for (int i = 0; i < w; i++) begin
            b[cnt] = gen[1] ? d[w - 1 - i] : d[i];
            cnt++;
        end
        if (frm[7]) begin
            b[cnt] = (^(d & ((9'h001 << w) - 9'h001))) ^ frm[6];
            cnt++;
        end
        b[cnt] = 1'b1;
        cnt++;
        if (frm[5:4] == STOP_TWO) begin
            b[cnt] = 1'b1;
            cnt++;
        end
        if (gen[2]) b = b ^ ((16'h0001 << cnt) - 16'h0001);
        return b;
    endfunction : frameBits

    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk("txd idle", 32'h1, txd);
        chk("irq", 32'h0, irq);
        rdChk(OFS_GENERAL, 32'h0);
        rdChk(OFS_FRAME, 32'h12);
        rdChk(OFS_SCALER, 32'h0);
        rdChk(8'h20, 32'h0);
        wr(8'h24, 32'hFFFFFFFF);
        rdChk(OFS_GENERAL, 32'h0);
        // link select set: frame write dropped, line stays idle
        wr(OFS_GENERAL, 32'h0B1);
        wr(OFS_TXDATA, 32'h55);
        repeat (4) @(posedge clock);
        rdChk(OFS_STATE, 32'h0);
        chk("txd idle", 32'h1, txd);
        // frame layouts, four sample periods of one cycle per bit
        for (int i = 0; i < 4; i++) begin
            wr(OFS_GENERAL, {23'h0, cg[i]});
            wr(OFS_FRAME, {24'h0, cf[i]});
            repeat (8) @(posedge clock);
            exp = frameBits(cg[i], cf[i], cd[i], n);
            fork
                wr(OFS_TXDATA, {23'h0, cd[i]});
                far_u.grab(~cg[i][2], n, 4, got, late);
            join
            if (late) begin
                badCount++;
                $display("unexpected wait: expected frame start seen timeout");
                closeOut;
            end
            chk("frame", exp, got);
            repeat (12) @(posedge clock);
            chk("idle level", {31'h0, ~cg[i][2]}, txd);
        end
        // ratio codes, integer scaler 2; ratio off keeps clock three times bit rate
        wr(OFS_MASK, 32'h1);
        wr(OFS_FRAME, 32'h12);
        wr(OFS_SCALER, 32'h40);
        for (int c = 0; c < 5; c++) begin
            wr(OFS_GENERAL, 32'h80 | (c << 4));
            rd(OFS_FLAGS, v);
            fork
                wr(OFS_TXDATA, 32'h0FF);
                span(lo, t);
            join
            chk("start length", ratio[c] * 3, lo);
        end
        rd(OFS_FLAGS, v);
        repeat (2) @(posedge clock);
        #1 chk("irq cleared", 32'h0, irq);
        // half fraction: 36 sample periods, 18 of them one cycle longer
        wr(OFS_GENERAL, 32'h0B0);
        wr(OFS_SCALER, 32'h10);
        fork
            wr(OFS_TXDATA, 32'h000);
            span(lo, t);
        join
        chk("fraction length", 32'd54, lo);
        // stop codes: each half bit adds two cycles
        wr(OFS_SCALER, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_FRAME, 32'h02 | (c << 4));
            rd(OFS_FLAGS, v);
            fork
                wr(OFS_TXDATA, 32'h0FF);
                span(lo, t);
            join
            dd[c] = t;
        end
        for (int c = 0; c < 4; c++) chk("stop length", 37 + 2 * c, dd[c]);
        // slow clock: half acts as one stop bit, one and a half as two
        wr(OFS_GENERAL, 32'h0C0);
        wr(OFS_SCALER, 32'h40);
        for (int c = 0; c < 4; c += 2) begin
            wr(OFS_FRAME, 32'h02 | (c << 4));
            rd(OFS_FLAGS, v);
            fork
                wr(OFS_TXDATA, 32'h0FF);
                span(lo, t);
            join
            chk("slow stop length", 29 + 3 * c / 2, t);
        end
        wr(OFS_SCALER, 32'h0);
        // receive, even parity, parity error unmasked only
        wr(OFS_GENERAL, 32'h130);
        wr(OFS_FRAME, 32'h92);
        wr(OFS_MASK, 32'h4);
        rd(OFS_FLAGS, v);
        exp = frameBits(9'h000, 8'h92, 9'h0A5, n);
        far_u.send(exp, n, 4);
        repeat (8) @(posedge clock);
        rdChk(OFS_RXDATA, 32'h0A5);
        chk("irq masked", 32'h0, irq);
        rd(OFS_FLAGS, v);
        far_u.send(exp ^ 16'h0200, n, 4);
        repeat (8) @(posedge clock);
        rdChk(OFS_RXDATA, 32'h2A5);
        chk("irq raised", 32'h1, irq);
        rdChk(OFS_FLAGS, 32'h6);
        repeat (2) @(posedge clock);
        #1 chk("irq cleared", 32'h0, irq);
        closeOut;
    end
endmodule : uafb_tb
`default_nettype wire
